// ### logic/pcg_pkg.sv
package pcg_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int NUM_REG = 3;

  // AXI response codes
  typedef logic [1:0] pcg_resp_t;
  localparam pcg_resp_t RESP_OKAY = 2'h0;
  localparam pcg_resp_t RESP_SLVERR = 2'h2;

  // Register byte offsets (base of each disable group of four words; config is a single word)
  localparam logic [ADDR_W-1:0] OFS_DISABLE_1 = 12'h090;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_2 = 12'h0A0;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_3 = 12'h0B0;
  localparam logic [ADDR_W-1:0] OFS_CONFIG_ZERO = 12'h0C0;

  // Alias word within a group: plain, clear, set, invert
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_DISABLE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_CONFIG_ZERO = 32'h00000000;

  // Lock bit position in the configuration register
  localparam int LOCK_POS = 12;

  // First disable register bit positions
  localparam int D1_SAR0 = 0;
  localparam int D1_LVD = 4;
  localparam int D1_SAR_SHR = 7;
  localparam int D1_CONV = 8;
  localparam int D1_TRIG = 11;
  localparam int D1_TOUCH = 15;
  localparam int D1_CAL = 16;
  localparam int D1_DMA = 19;
  localparam int D1_ACRYPT = 23;
  localparam int D1_CRYPT = 24;
  localparam int D1_RNG = 26;
  localparam int D1_QSER = 29;

  // Second disable register field bases
  localparam int D2_ICAP = 0;
  localparam int D2_OCMP = 8;
  localparam int D2_TMR = 16;
  localparam int D2_REFO = 28;

  // Third disable register bit positions
  localparam int D3_UART = 0;
  localparam int D3_ETH = 4;
  localparam int D3_SPI = 8;
  localparam int D3_WIFI = 12;
  localparam int D3_I2C = 16;
  localparam int D3_USB = 24;
  localparam int D3_CAN = 27;

  // Implemented-bit masks built from the positions above
  localparam logic [DATA_W-1:0] MASK_DISABLE_1 =
    (32'h1 << D1_SAR0) | (32'h1 << D1_LVD) | (32'h1 << D1_SAR_SHR) |
    (32'h1 << D1_CONV) | (32'h1 << D1_TRIG) | (32'h1 << D1_TOUCH) |
    (32'h1 << D1_CAL) | (32'h1 << D1_DMA) | (32'h1 << D1_ACRYPT) |
    (32'h1 << D1_CRYPT) | (32'h1 << D1_RNG) | (32'h1 << D1_QSER);
  localparam logic [DATA_W-1:0] MASK_DISABLE_2 =
    (32'hF << D2_ICAP) | (32'hF << D2_OCMP) | (32'h7F << D2_TMR) |
    (32'hF << D2_REFO);
  localparam logic [DATA_W-1:0] MASK_DISABLE_3 =
    (32'h7 << D3_UART) | (32'h1 << D3_ETH) | (32'h3 << D3_SPI) |
    (32'h1 << D3_WIFI) | (32'h3 << D3_I2C) | (32'h1 << D3_USB) |
    (32'h3 << D3_CAN);
  localparam logic [DATA_W-1:0] MASK_CONFIG_ZERO = 32'h1 << LOCK_POS;
endpackage : pcg_pkg

// ### logic/pcg_clock_gate.sv
`timescale 1ns/10ps
// Glitch-free clock gate for one peripheral
module pcg_clock_gate (
  input wire logic clk,
  input wire logic enable,
  output wire logic gated_clk
);
  import pcg_pkg::*;

  logic enable_latched; // Enable held while clock is high

  // Latch is open only while the clock is low
  always_latch begin
    if (!clk) begin
      enable_latched <= enable;
    end
  end

  // Output can only change state at a clock edge
  assign gated_clk = clk & enable_latched;
endmodule : pcg_clock_gate

// ### logic/pcg_top.sv
`timescale 1ns/10ps
// What this block does
// - Set disable bit stops that peripheral's clock
// - One disables a peripheral, zero enables
// - All disable bits reset to zero
// - Disabled peripheral ignores register writes, reads invalid
// - Lock bit twelve blocks all disable writes
// - Clear, set, invert aliases at plus 4, 8, C
// - First register maps converters, crypto, DMA, others
// - Second register maps captures, compares, timers, references
// - Third register maps serial, network, USB, CAN
// - Unimplemented bits read zero, ignore writes
module pcg_top (
  input wire logic clk,
  input wire logic rst_b,
  // Write address channel
  input wire logic [pcg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,
  // Write data channel
  input wire logic [pcg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [pcg_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,
  // Write response channel
  output wire pcg_pkg::pcg_resp_t s_axi_bresp,
  output wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [pcg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,
  // Read data channel
  output wire logic [pcg_pkg::DATA_W-1:0] s_axi_rdata,
  output wire pcg_pkg::pcg_resp_t s_axi_rresp,
  output wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Gated clocks, one bit per peripheral slot
  output wire logic [pcg_pkg::DATA_W-1:0] periph_clk_1,
  output wire logic [pcg_pkg::DATA_W-1:0] periph_clk_2,
  output wire logic [pcg_pkg::DATA_W-1:0] periph_clk_3,
  // Register access enables for each peripheral
  output wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_1,
  output wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_2,
  output wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_3,
  // Lock state seen by other locked blocks
  output wire logic gate_config_lock
);
  import pcg_pkg::*;

  localparam int ALL_W = NUM_REG * DATA_W; // Total gate slots

  // Write channel sequencing states
  typedef enum logic [1:0] {
    WR_COLLECT,
    WR_EXEC,
    WR_RESP
  } pcg_wr_state_t;

  // Register file
  logic [DATA_W-1:0] peripheral_disable_1_r; // First disable register
  logic [DATA_W-1:0] peripheral_disable_2_r; // Second disable register
  logic [DATA_W-1:0] peripheral_disable_3_r; // Third disable register
  logic [DATA_W-1:0] config_register_zero_r; // Holds the lock bit
  logic [DATA_W-1:0] peripheral_disable_1_nxt; // Next first register
  logic [DATA_W-1:0] peripheral_disable_2_nxt; // Next second register
  logic [DATA_W-1:0] peripheral_disable_3_nxt; // Next third register
  logic [DATA_W-1:0] config_register_zero_nxt; // Next config register

  // Write channel state
  pcg_wr_state_t wr_state_r; // Current write state
  pcg_wr_state_t wr_state_nxt; // Next write state
  logic aw_held_r; // Write address captured
  logic w_held_r; // Write data captured
  logic [ADDR_W-1:0] awaddr_r; // Captured write address
  logic [DATA_W-1:0] wdata_r; // Captured write data
  logic [STRB_W-1:0] wstrb_r; // Captured byte strobes
  pcg_resp_t bresp_r; // Write response code

  // Read channel state
  logic rvalid_r; // Read data pending
  logic [DATA_W-1:0] rdata_r; // Read data held
  pcg_resp_t rresp_r; // Read response code

  // Handshake decode
  wire aw_take = s_axi_awvalid & s_axi_awready; // Address taken
  wire w_take = s_axi_wvalid & s_axi_wready; // Data taken
  wire ar_take = s_axi_arvalid & s_axi_arready; // Read taken
  wire b_done = s_axi_bvalid & s_axi_bready; // Response taken
  wire r_done = s_axi_rvalid & s_axi_rready; // Read data taken

  // Write address decode
  wire [ADDR_W-1:0] wr_base = {awaddr_r[ADDR_W-1:4], 4'h0}; // Group base
  wire [1:0] wr_alias = awaddr_r[3:2]; // Alias selector
  wire wr_sel_1 = (wr_base == OFS_DISABLE_1);
  wire wr_sel_2 = (wr_base == OFS_DISABLE_2);
  wire wr_sel_3 = (wr_base == OFS_DISABLE_3);
  wire wr_sel_cfg = (awaddr_r[ADDR_W-1:2] == OFS_CONFIG_ZERO[ADDR_W-1:2]);
  wire wr_sel_dis = wr_sel_1 | wr_sel_2 | wr_sel_3; // Any disable group
  wire wr_hit = wr_sel_dis | wr_sel_cfg; // Mapped write
  wire wr_locked = config_register_zero_r[LOCK_POS];
  wire wr_exec = (wr_state_r == WR_EXEC); // Write applies now
  wire wr_dis_en = wr_exec & wr_sel_dis & ~wr_locked;

  // Read address decode
  wire [ADDR_W-1:0] rd_base = {s_axi_araddr[ADDR_W-1:4], 4'h0}; // Group base
  wire rd_sel_1 = (rd_base == OFS_DISABLE_1); // Any alias reads register
  wire rd_sel_2 = (rd_base == OFS_DISABLE_2); // Any alias reads register
  wire rd_sel_3 = (rd_base == OFS_DISABLE_3); // Any alias reads register
  wire rd_sel_cfg = (s_axi_araddr[ADDR_W-1:2] == OFS_CONFIG_ZERO[ADDR_W-1:2]);
  wire rd_hit = rd_sel_1 | rd_sel_2 | rd_sel_3 | rd_sel_cfg; // Mapped read

  // Byte-lane mask from strobes
  wire [DATA_W-1:0] strb_mask; // Expanded strobes
  genvar gb;
  generate
    for (gb = 0; gb < STRB_W; gb++) begin : g_strb
      assign strb_mask[gb*8 +: 8] = {8{wstrb_r[gb]}};
    end
  endgenerate

  // Read data selection
  wire [DATA_W-1:0] rd_value =
    ({DATA_W{rd_sel_1}} & peripheral_disable_1_r) |
    ({DATA_W{rd_sel_2}} & peripheral_disable_2_r) |
    ({DATA_W{rd_sel_3}} & peripheral_disable_3_r) |
    ({DATA_W{rd_sel_cfg}} & config_register_zero_r);

  // Apply a plain, clear, set or invert write to one register
  function automatic logic [DATA_W-1:0] alias_apply(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] data,
    input logic [DATA_W-1:0] lanes,
    input logic [1:0] alias_sel,
    input logic [DATA_W-1:0] impl
  );
    logic [DATA_W-1:0] bits;
    logic [DATA_W-1:0] res;
    bits = data & lanes;
    case (alias_sel)
      ALIAS_PLAIN: res = (cur & ~lanes) | bits; // Plain write
      ALIAS_CLR: res = cur & ~bits;
      ALIAS_SET: res = cur | bits;
      ALIAS_INV: res = cur ^ bits;
      default: res = cur; // Hold
    endcase
    alias_apply = res & impl;
  endfunction : alias_apply

  // Next values of the disable registers
  assign peripheral_disable_1_nxt = (wr_dis_en && wr_sel_1) ?
    alias_apply(peripheral_disable_1_r, wdata_r, strb_mask, wr_alias,
                MASK_DISABLE_1) : peripheral_disable_1_r;
  assign peripheral_disable_2_nxt = (wr_dis_en && wr_sel_2) ?
    alias_apply(peripheral_disable_2_r, wdata_r, strb_mask, wr_alias,
                MASK_DISABLE_2) : peripheral_disable_2_r;
  assign peripheral_disable_3_nxt = (wr_dis_en && wr_sel_3) ?
    alias_apply(peripheral_disable_3_r, wdata_r, strb_mask, wr_alias,
                MASK_DISABLE_3) : peripheral_disable_3_r;

  // Config register takes plain writes only, lock or not
  assign config_register_zero_nxt = (wr_exec && wr_sel_cfg) ?
    alias_apply(config_register_zero_r, wdata_r, strb_mask, ALIAS_PLAIN,
                MASK_CONFIG_ZERO) : config_register_zero_r;

  // Register file update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peripheral_disable_1_r <= RST_DISABLE;
      peripheral_disable_2_r <= RST_DISABLE;
      peripheral_disable_3_r <= RST_DISABLE;
      config_register_zero_r <= RST_CONFIG_ZERO;
    end else begin
      peripheral_disable_1_r <= peripheral_disable_1_nxt;
      peripheral_disable_2_r <= peripheral_disable_2_nxt;
      peripheral_disable_3_r <= peripheral_disable_3_nxt;
      config_register_zero_r <= config_register_zero_nxt;
    end
  end

  // Write state sequencing
  always_comb begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      WR_COLLECT: begin
        // Move on once address and data are both in
        if ((aw_held_r | aw_take) & (w_held_r | w_take)) begin
          wr_state_nxt = WR_EXEC;
        end
      end
      WR_EXEC: begin
        wr_state_nxt = WR_RESP; // Register updated this edge
      end
      WR_RESP: begin
        if (b_done) begin
          wr_state_nxt = WR_COLLECT;
        end
      end
      default: begin
        wr_state_nxt = WR_COLLECT;
      end
    endcase
  end

  // Write state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_state_r <= WR_COLLECT;
    end else begin
      wr_state_r <= wr_state_nxt;
    end
  end

  // Capture write address in either order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (b_done) begin
      aw_held_r <= 1'b0;
    end
  end

  // Capture write data in either order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (b_done) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response code, locked writes still answer okay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bresp_r <= RESP_OKAY;
    end else if (wr_exec) begin
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read channel: one beat, held until taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_value;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      rvalid_r <= 1'b0;
    end
  end

  // Bus outputs
  assign s_axi_awready = (wr_state_r == WR_COLLECT) & ~aw_held_r;
  assign s_axi_wready = (wr_state_r == WR_COLLECT) & ~w_held_r;
  assign s_axi_bvalid = (wr_state_r == WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // All disable bits and implemented slots side by side
  wire [ALL_W-1:0] dis_all = {peripheral_disable_3_r, peripheral_disable_2_r,
                              peripheral_disable_1_r};
  // Constant, so the gate loop below can choose per slot at elaboration
  localparam logic [ALL_W-1:0] MASK_ALL = {MASK_DISABLE_3, MASK_DISABLE_2,
                                           MASK_DISABLE_1};
  wire [ALL_W-1:0] run_all = MASK_ALL & ~dis_all;
  wire [ALL_W-1:0] gclk_all; // Gated clocks, all slots

  // One gate per implemented slot, empty slots held low
  genvar gi;
  generate
    for (gi = 0; gi < ALL_W; gi++) begin : g_gate
      if (MASK_ALL[gi]) begin : g_impl
        pcg_clock_gate u_gate (
          .clk(clk),
          .enable(run_all[gi]),
          .gated_clk(gclk_all[gi])
        );
      end else begin : g_empty
        assign gclk_all[gi] = 1'b0;
      end
    end
  endgenerate

  // Gated clock outputs
  assign periph_clk_1 = gclk_all[DATA_W-1:0];
  assign periph_clk_2 = gclk_all[2*DATA_W-1:DATA_W];
  assign periph_clk_3 = gclk_all[ALL_W-1:2*DATA_W];

  // Register access enables, low while disabled
  assign periph_regs_en_1 = run_all[DATA_W-1:0];
  assign periph_regs_en_2 = run_all[2*DATA_W-1:DATA_W];
  assign periph_regs_en_3 = run_all[ALL_W-1:2*DATA_W];

  // Lock state out
  assign gate_config_lock = wr_locked;
endmodule : pcg_top

// ### test/pcg_top_sva.sv
`timescale 1ns/10ps
// Watches the register bus handshake and the gated clock outputs
module pcg_top_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [pcg_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_clk_1,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_clk_2,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_clk_3,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_1,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_2,
  input wire logic [pcg_pkg::DATA_W-1:0] periph_regs_en_3,
  input wire logic gate_config_lock
);
  import pcg_pkg::*;
  // All slots side by side, first register lowest
  wire logic [95:0] en_all = {periph_regs_en_3, periph_regs_en_2, periph_regs_en_1};
  wire logic [95:0] clk_all = {periph_clk_3, periph_clk_2, periph_clk_1};
  wire logic [95:0] impl = {MASK_DISABLE_3, MASK_DISABLE_2, MASK_DISABLE_1};
  // Bus side samples on the rising edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_all_on: assert property ($rose(rst_b) |-> en_all == impl)
    else $error("enables not all set after reset");
  a_unimpl_quiet: assert property (((en_all | clk_all) & ~impl) == '0)
    else $error("unimplemented slot enabled or clocked");
  // High phase seen at the falling edge; latch holds the last low-phase enable
  a_gate_follows: assert property (@(negedge clk) disable iff (!rst_b)
    clk_all == $past(en_all)) else $error("gated clock does not follow enable");
  a_lock_freezes: assert property (gate_config_lock |=> $stable(en_all))
    else $error("disable bits changed while locked");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule : pcg_top_sva

// ### test/pcg_top_test.sv
`timescale 1ns/10ps
// Self-checking bench for the peripheral clock gate
module pcg_top_test;
  import pcg_pkg::*;
  logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, gate_config_lock;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, periph_clk_1, periph_clk_2, periph_clk_3;
  logic [DATA_W-1:0] periph_regs_en_1, periph_regs_en_2, periph_regs_en_3;
  logic [STRB_W-1:0] s_axi_wstrb;
  pcg_resp_t s_axi_bresp, s_axi_rresp;
  int n_fail;
  int n_checks;
  // Implemented slots, first register in the low word
  logic [95:0] impl = {32'h19031317, 32'hF07F0F0F, 32'h25898991};
  wire logic [95:0] en_all = {periph_regs_en_3, periph_regs_en_2, periph_regs_en_1};
  wire logic [95:0] clk_all = {periph_clk_3, periph_clk_2, periph_clk_1};
  pcg_top i_pcg_top (.*);
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Base address of group i; group 3 is the lock holder
  function automatic logic [ADDR_W-1:0] base(input int i);
    return OFS_DISABLE_1 + 12'(16 * i);
  endfunction : base
  // One write, address and data offered together
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [STRB_W-1:0] s, input pcg_resp_t r);
    logic at, wt, bt;
    int n;
    n = 0;
    bt = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bt && n < 40) begin
      @(negedge clk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid && s_axi_bready;
      if (bt) chk(96'(s_axi_bresp), 96'(r));
      @(posedge clk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      if (bt) s_axi_bready <= 1'b0;
      n++;
    end
    chk(96'(bt), 96'h1);
  endtask : wr
  // One read; ready is raised only once data is seen
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input pcg_resp_t r);
    logic art, rv, rt;
    int n;
    n = 0;
    rt = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rt && n < 40) begin
      @(negedge clk);
      art = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rt = rv && s_axi_rready;
      if (rt) chk(96'({s_axi_rresp, s_axi_rdata}), 96'({r, d}));
      @(posedge clk);
      if (art) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !rt;
      n++;
    end
    chk(96'(rt), 96'h1);
  endtask : rd
  // Reset values of all registers and enables
  task automatic t_reset;
    chk(en_all, impl);
    for (int i = 0; i < 4; i++) rd(base(i), 32'h0, RESP_OKAY);
  endtask : t_reset
  // Disable a whole register; only its clocks stop
  task automatic t_map;
    logic [95:0] exp;
    for (int i = 0; i < 3; i++) begin
      wr(base(i), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rd(base(i), impl[32*i +: 32], RESP_OKAY);
      exp = impl;
      exp[32*i +: 32] = '0;
      @(posedge clk);
      #5;
      chk(en_all, exp);
      chk(clk_all, exp);
      wr(base(i), 32'h0, 4'hF, RESP_OKAY);
    end
  endtask : t_map
  // Plain, clear, set, invert words and lane strobes
  task automatic t_alias;
    logic [31:0] v;
    logic [31:0] d [4] = '{32'hFFFF0000, 32'hF0F0F0F0, 32'h0000FFFF, 32'hFFFFFFFF};
    for (int i = 0; i < 3; i++) begin
      v = '0;
      for (int k = 0; k < 4; k++) begin
        wr(base(i) + 12'(4 * k), d[k], 4'hF, RESP_OKAY);
        v = (k == 0) ? d[k] : (k == 1) ? v & ~d[k] : (k == 2) ? v | d[k] : v ^ d[k];
        v = v & impl[32*i +: 32];
        rd(base(i) + 12'(4 * k), v, RESP_OKAY);
      end
      wr(base(i) + 12'h8, 32'hFFFFFFFF, 4'h2, RESP_OKAY);
      rd(base(i), v | (32'h0000FF00 & impl[32*i +: 32]), RESP_OKAY);
      wr(base(i), 32'h0, 4'hF, RESP_OKAY);
    end
  endtask : t_alias
  // Locked writes are answered but ignored
  task automatic t_lock;
    wr(base(3), 32'h00001000, 4'hF, RESP_OKAY);
    rd(base(3), 32'h00001000, RESP_OKAY);
    chk(96'(gate_config_lock), 96'h1);
    for (int i = 0; i < 3; i++) begin
      wr(base(i) + 12'h8, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rd(base(i), 32'h0, RESP_OKAY);
    end
    wr(base(3), 32'h0, 4'hF, RESP_OKAY);
    wr(base(0), 32'h00080000, 4'hF, RESP_OKAY);
    rd(base(0), 32'h00080000, RESP_OKAY);
    wr(base(0), 32'h0, 4'hF, RESP_OKAY);
  endtask : t_lock
  // Unmapped places answer an error and change nothing
  task automatic t_unmapped;
    wr(12'h0C4, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    rd(12'h100, 32'h0, RESP_SLVERR);
    rd(base(3), 32'h0, RESP_OKAY);
  endtask : t_unmapped
  // Reset in mid-run clears disable bits
  task automatic t_mid_reset;
    wr(base(2), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(base(2), 32'h0, RESP_OKAY);
    chk(en_all, impl);
  endtask : t_mid_reset
  // Verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_map();
    t_alias();
    t_lock();
    t_unmapped();
    t_mid_reset();
    complete_run();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule : pcg_top_test
bind pcg_top pcg_top_sva i_pcg_top_sva (.*);
